// ### bench/host_model.sv
// Host system logic that takes words from the system output.
// Assumes the design holds each word until it is taken.
`timescale 1ns/1ps
module host_model (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        hold,
  input  wire logic        sys_out_valid,
  input  wire logic [31:0] sys_out_data,
  input  wire logic        sys_out_status,
  output logic             sys_out_ready
);
  logic [32:0] q [$];
  logic        ph_q;
  // Half-rate ready keeps the design stalling inside packets
  assign sys_out_ready = !hold && ph_q;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ph_q <= 1'b0;
    end else begin
      ph_q <= !ph_q;
      if (sys_out_valid && sys_out_ready) q.push_back({sys_out_status, sys_out_data});
    end
  end
endmodule

// ### bench/pdsw_checker.sv
// Concurrent checks on the discard block's system and transmit ports.
// Assumes a bind onto the design top; one clock domain, mclk.
`timescale 1ns/1ps
module pdsw_checker
  import discard_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic [1:0]  tx_code,
  input wire logic        tx_sys_ready,
  input wire logic        tx_sys_busy,
  input wire logic        tx_pkt_active,
  input wire logic        tx_discard_flag,
  input wire logic        tx_discard_clear,
  input wire logic        rx_discard_flag,
  input wire logic        rx_discard_clear,
  input wire logic        auto_clear_en,
  input wire logic        auto_rx_abort_en,
  input wire logic        rx_abort_in,
  input wire logic        sys_out_valid,
  input wire logic        sys_out_ready,
  input wire logic        sys_out_status,
  input wire logic [31:0] sys_out_data,
  input wire logic        big_endian
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_err_once; tx_code == TXC_ERR |=> tx_code == TXC_IDLE; endproperty
  a_err_once: assert property (p_err_once) else $error("error code too long");
  property p_refuse; tx_code == TXC_ERR |-> !tx_sys_ready; endproperty
  a_refuse: assert property (p_refuse) else $error("tx data not refused");
  property p_tx_set; $rose(tx_discard_flag) |-> $past(tx_sys_busy); endproperty
  a_tx_set: assert property (p_tx_set) else $error("tx flag without input");
  property p_tx_back; !tx_sys_ready && !tx_sys_busy && !tx_pkt_active |-> ##[1:2] tx_sys_ready;
  endproperty
  a_tx_back: assert property (p_tx_back) else $error("tx ready stuck");
  property p_tx_stick; tx_discard_flag && !tx_discard_clear && !auto_clear_en |=> tx_discard_flag;
  endproperty
  a_tx_stick: assert property (p_tx_stick) else $error("tx flag dropped");
  property p_rx_stick; rx_discard_flag && !rx_discard_clear && !auto_clear_en |=> rx_discard_flag;
  endproperty
  a_rx_stick: assert property (p_rx_stick) else $error("rx flag dropped");
  property p_rsv; sys_out_valid && sys_out_status && !big_endian |-> sys_out_data[15:6] == 10'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved status bits set");
  property p_hold; sys_out_valid && !sys_out_ready && !rx_abort_in && !auto_rx_abort_en
    |=> sys_out_valid && $stable(sys_out_data); endproperty
  a_hold: assert property (p_hold) else $error("output word not held");
endmodule
bind packet_discard_status_word pdsw_checker chk (.*);

// ### bench/tb_packet_discard_status_word.sv
// Self-checking bench of the discard and status word block.
// Assumes host_model on the system side and the bound checker.
`timescale 1ns/1ps
module tb_packet_discard_status_word
  import discard_pkg::*;
;
  logic        mclk = 1'b0, nrst = 1'b0, hold = 1'b0, rx_in_valid = 1'b0;
  logic        rx_in_sop = 1'b0, rx_in_eop = 1'b0, rx_in_code_err = 1'b0;
  logic        rx_in_crc_bad = 1'b0, rx_abort_in = 1'b0, rx_discard_clear = 1'b0;
  logic        tx_pkt_active = 1'b0, tx_pkt_end = 1'b0, tx_sys_busy = 1'b0;
  logic        tx_fifo_underflow = 1'b0, tx_fifo_overflow = 1'b0, tx_discard_clear = 1'b0;
  logic        auto_clear_en = 1'b0, auto_rx_abort_en = 1'b0, abort_keeps_status = 1'b0;
  logic        big_endian = 1'b0, rx_in_ready, sys_out_valid, sys_out_ready, sys_out_eop;
  logic        sys_out_status, rx_discard_flag, tx_sys_ready, tx_discard_flag;
  logic [31:0] rx_in_data = 32'h0, sys_out_data;
  logic [2:0]  rx_in_nbytes = 3'h4;
  logic [1:0]  status_word_select = SEL_GOOD, tx_code;
  logic [4:0]  discard_en = 5'h1f;
  logic [15:0] max_pkt_size = 16'h0100;
  int          err_count = 0, n_tests = 0;
  int          cs_nw [4] = '{16, 16, 17, 16};
  logic [2:0]  cs_nb [4] = '{3'h4, 3'h3, 3'h4, 3'h4};
  logic [31:0] cs_st [4] = '{32'h003c_0001, 32'h003b_0004, 32'h0040_0008, 32'h003c_0010};
  // Depth 64 lets a held packet and a whole discarded one wait together
  packet_discard_status_word #(.DEPTH(64)) dut (.*);
  host_model host (.mclk, .nrst, .hold, .sys_out_valid, .sys_out_data, .sys_out_status,
                   .sys_out_ready);
  always #12.5 mclk = ~mclk;
  function automatic logic [31:0] word(int i);
    return 32'h03020100 + 32'h04040404 * i;
  endfunction
  function automatic logic [31:0] ord(logic [31:0] x);
    return big_endian ? {<<8{x}} : x;
  endfunction
  task automatic tick(int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(logic [32:0] got, logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic send(int nw, logic [2:0] nb, logic crc, logic cw);
    for (int i = 0; i < nw; i++) begin
      rx_in_valid <= 1'b1;
      rx_in_sop <= (i == 0);
      rx_in_eop <= (i == nw - 1);
      rx_in_data <= word(i);
      rx_in_nbytes <= (i == nw - 1) ? nb : 3'h4;
      rx_in_crc_bad <= crc;
      rx_in_code_err <= cw && (i == 2);
      tick();
    end
    rx_in_valid <= 1'b0;
    tick(6);
  endtask
  task automatic expect_w(logic [32:0] exp);
    int t = 0;
    while (host.q.size() == 0 && t < 300) begin
      tick();
      t++;
    end
    if (host.q.size() == 0) begin
      err_count++;
      report_and_stop();
    end else chk(host.q.pop_front(), exp);
  endtask
  task automatic get_pkt(int nw, logic [31:0] sts);
    for (int i = 0; i < nw; i++) expect_w({1'b0, ord(word(i))});
    expect_w({1'b1, ord(sts)});
  endtask
  initial begin
    tick(16);
    nrst <= 1'b1;
    tick(2);
    for (int e = 0; e < 2; e++) begin
      big_endian <= (e == 0);
      send(16, 3'h4, 1'b0, 1'b0);
      get_pkt(16, 32'h003c_0000);
      $display("test good packet %0d done", e);
    end
    max_pkt_size <= 16'h0040;
    status_word_select <= SEL_ALL;
    for (int k = 0; k < 4; k++) begin
      // A good packet parked ahead keeps the faulty one wholly inside the FIFO
      hold <= 1'b1;
      send(16, 3'h4, 1'b0, 1'b0);
      send(cs_nw[k], cs_nb[k], k == 0, k == 3);
      hold <= 1'b0;
      get_pkt(16, 32'h003c_0000);
      get_pkt(0, cs_st[k]);
      $display("test discard %0d done", k);
    end
    discard_en <= 5'h1e;
    status_word_select <= SEL_GOOD;
    send(16, 3'h4, 1'b1, 1'b0);
    get_pkt(16, 32'h003c_0001);
    discard_en <= 5'h1f;
    send(16, 3'h4, 1'b1, 1'b0);
    for (int i = 0; i < 16; i++) expect_w({1'b0, word(i)});
    chk(rx_discard_flag, 1'b1);
    status_word_select <= SEL_NONE;
    send(16, 3'h4, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++) expect_w({1'b0, word(i)});
    tick(20);
    chk(host.q.size(), 0);
    $display("test keep and no status done");
    discard_en <= 5'h00;
    status_word_select <= SEL_GOOD;
    for (int k = 0; k < 2; k++) begin
      abort_keeps_status <= k[0];
      hold <= 1'b1;
      send(2, 3'h4, 1'b0, 1'b0);
      rx_abort_in <= 1'b1;
      tick();
      rx_abort_in <= 1'b0;
      tick(7);
      chk(sys_out_valid, 1'b0);
      tick();
      chk(sys_out_valid, k[0]);
      hold <= 1'b0;
      if (k == 1) expect_w({1'b1, 32'h0004_0004});
      tick(20);
      chk(host.q.size(), 0);
      $display("test abort %0d done", k);
    end
    for (int k = 0; k < 2; k++) begin
      tx_pkt_active <= 1'b1;
      tx_sys_busy <= 1'b1;
      tick(3);
      chk(tx_code, TXC_DATA);
      tx_fifo_underflow <= (k == 0);
      tx_fifo_overflow <= (k == 1);
      tick();
      tx_fifo_underflow <= 1'b0;
      tx_fifo_overflow <= 1'b0;
      chk({tx_discard_flag, tx_sys_ready, tx_code}, {2'h2, TXC_ERR});
      tick();
      chk({tx_sys_ready, tx_code}, {1'b0, TXC_IDLE});
      tx_sys_busy <= 1'b0;
      tx_pkt_active <= 1'b0;
      tick(3);
      chk(tx_sys_ready, 1'b1);
      if (k == 1) begin
        auto_clear_en <= 1'b1;
        tx_pkt_end <= 1'b1;
        tick();
        tx_pkt_end <= 1'b0;
        tick(2);
        chk(tx_discard_flag, 1'b1);
        tick();
        chk(tx_discard_flag, 1'b0);
        auto_clear_en <= 1'b0;
      end
      tx_discard_clear <= 1'b1;
      rx_discard_clear <= 1'b1;
      tick();
      chk({tx_discard_flag, rx_discard_flag}, 2'h0);
      tx_discard_clear <= 1'b0;
      rx_discard_clear <= 1'b0;
      $display("test transmit discard %0d done", k);
    end
    report_and_stop();
  end
endmodule

// ### logic/discard_pkg.sv
// Constants, field layouts and state types of the packet discard block.
// Assumes one system clock; every consumer imports the whole package.
package discard_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int          DATA_W       = 32;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          ENTRY_W      = 34;
  localparam int          E_EOP        = 32;
  localparam int          E_STS        = 33;

  // ----------------------------------------------------------------
  // Packet limits and cycle counts
  // ----------------------------------------------------------------
  localparam logic [15:0] MIN_PKT_BYTES  = 16'h0040;
  localparam logic [15:0] CRC_BYTES      = 16'h0004;
  localparam int          FLUSH_SHIFT    = 3;
  localparam logic [15:0] FLUSH_EXTRA    = 16'h0006;
  localparam logic [1:0]  AUTO_CLR_DELAY = 2'h3;

  // ----------------------------------------------------------------
  // Status word bit positions and discard enable bits
  // ----------------------------------------------------------------
  localparam int          ST_CRC   = 0;
  localparam int          ST_RX_OVERFLOW_FLAG  = 1;
  localparam int          ST_UNDERSIZE_FLAG = 2;
  localparam int          ST_OVERSIZE_FLAG = 3;
  localparam int          ST_CODEWORD_ERROR  = 4;
  localparam int          ST_MULTI = 5;
  localparam int          ST_BC_LO = 16;
  localparam int          N_DISC   = 5;

  // ----------------------------------------------------------------
  // Status word select and transmit line codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  SEL_GOOD = 2'h0;
  localparam logic [1:0]  SEL_ALL  = 2'h1;
  localparam logic [1:0]  SEL_NONE = 2'h2;
  localparam logic [1:0]  TXC_IDLE = 2'h0;
  localparam logic [1:0]  TXC_DATA = 2'h1;
  localparam logic [1:0]  TXC_ERR  = 2'h2;

  typedef enum logic [2:0] {RX_IDLE, RX_DATA, RX_DECIDE, RX_TERM, RX_STS} rx_state_t;
  typedef enum logic [1:0] {OUT_RUN, OUT_DRAIN, OUT_DROPSTS} out_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_RUN, TX_ERR, TX_HOLD} tx_state_t;

endpackage

// ### logic/packet_discard_status_word.sv
// Receive FIFO with packet rewind, plus the discard and status word logic.
// Assumes all inputs are synchronous to mclk and the coding layer cannot
// be stalled, so a full FIFO loses words instead of back-pressuring.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Packet FIFO: rewind drops every word written since the last mark
// ------------------------------------------------------------------
module rx_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             mark,
  input  wire logic             rewind,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("rx_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic [AW:0]      mark_ptr_q;
  wire              do_wr = wr_valid && wr_ready && !rewind;
  wire              do_rd = rd_valid && rd_ready;

  assign level    = wr_ptr_q - rd_ptr_q;
  assign wr_ready = level != (AW + 1)'(DEPTH);
  assign rd_valid = level != '0;
  assign rd_data  = mem[rd_ptr_q[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr_q[AW-1:0]] <= wr_data;
    end
  end

  // Rewind is only legal while the reader has not entered the packet
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      mark_ptr_q <= '0;
    end else begin
      if (mark) begin
        mark_ptr_q <= wr_ptr_q;
      end
      if (rewind) begin
        wr_ptr_q <= mark_ptr_q;
      end else if (do_wr) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule

module packet_discard_status_word
  import discard_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              rx_in_valid,
  input  wire logic              rx_in_sop,
  input  wire logic              rx_in_eop,
  input  wire logic [DATA_W-1:0] rx_in_data,
  input  wire logic [2:0]        rx_in_nbytes,
  input  wire logic              rx_in_code_err,
  input  wire logic              rx_in_crc_bad,
  output logic                   rx_in_ready,
  output logic                   sys_out_valid,
  input  wire logic              sys_out_ready,
  output logic [DATA_W-1:0]      sys_out_data,
  output logic                   sys_out_eop,
  output logic                   sys_out_status,
  input  wire logic              rx_abort_in,
  output logic                   rx_discard_flag,
  input  wire logic              rx_discard_clear,
  input  wire logic              tx_pkt_active,
  input  wire logic              tx_pkt_end,
  input  wire logic              tx_sys_busy,
  input  wire logic              tx_fifo_underflow,
  input  wire logic              tx_fifo_overflow,
  output logic                   tx_sys_ready,
  output logic [1:0]             tx_code,
  output logic                   tx_discard_flag,
  input  wire logic              tx_discard_clear,
  input  wire logic              auto_clear_en,
  input  wire logic              auto_rx_abort_en,
  input  wire logic              abort_keeps_status,
  input  wire logic [1:0]        status_word_select,
  input  wire logic [N_DISC-1:0] discard_en,
  input  wire logic              big_endian,
  input  wire logic [15:0]       max_pkt_size
);
  localparam int LW = $clog2(DEPTH) + 1;

  generate
    if (DEPTH < 4) begin : g_bad_depth
      $error("receive FIFO needs at least 4 words");
    end
  endgenerate

  function automatic logic [DATA_W-1:0] swap32(input logic [DATA_W-1:0] w);
    swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rx_state_t         in_st_q;
  rx_state_t         in_st_d;
  out_state_t        out_st_q;
  out_state_t        out_st_d;
  tx_state_t         tx_st_q;
  tx_state_t         tx_st_d;
  logic [15:0]       in_bytes_q;
  logic [15:0]       pkt_words_q;
  logic              rx_overflow_flag_q;
  logic              code_q;
  logic              crc_q;
  logic              eop_lost_q;
  logic              aborted_q;
  logic              pend_q;
  logic [DATA_W-1:0] pend_word_q;
  logic              mid_q;
  logic [15:0]       flush_q;
  logic [1:0]        clr_cnt_q;
  logic              rx_flag_q;
  logic              tx_flag_q;
  logic              rx_ready_q;
  logic              out_valid_q;
  logic [DATA_W-1:0] out_data_q;
  logic              out_eop_q;
  logic              out_sts_q;
  logic              tx_ready_q;
  logic [1:0]        tx_code_q;

  logic               f_wr_ready;
  logic               f_rd_valid;
  logic [ENTRY_W-1:0] f_rd_data;
  logic [LW-1:0]      f_level;

  // ----------------------------------------------------------------
  // Ingress decode
  // ----------------------------------------------------------------
  wire in_idle   = in_st_q == RX_IDLE;
  wire beat      = rx_in_valid && (in_idle ? rx_in_sop : in_st_q == RX_DATA);
  wire sop_beat  = beat && in_idle;
  // Once overflowed, the rest of the packet is dropped even if room frees
  wire keep_cnt  = sop_beat || !rx_overflow_flag_q;
  wire data_wr   = beat && f_wr_ready && keep_cnt;
  wire rx_overflow_flag_evt  = beat && !data_wr;
  wire in_eop    = beat && rx_in_eop;

  wire [N_DISC:0] err_w;
  assign err_w[ST_CRC]   = crc_q;
  assign err_w[ST_RX_OVERFLOW_FLAG]  = rx_overflow_flag_q;
  assign err_w[ST_UNDERSIZE_FLAG] = in_bytes_q < MIN_PKT_BYTES;
  assign err_w[ST_OVERSIZE_FLAG] = in_bytes_q > max_pkt_size;
  assign err_w[ST_CODEWORD_ERROR]  = code_q;
  assign err_w[ST_MULTI] = 1'b0;

  wire hit      = (|(err_w[N_DISC-1:0] & discard_en)) || aborted_q;
  wire started  = 16'(f_level) < pkt_words_q;
  wire decide   = in_st_q == RX_DECIDE;
  wire internal = decide && hit && !started;
  wire external = decide && hit && started;
  wire sts_want = (status_word_select == SEL_ALL) ||
                  (status_word_select == SEL_GOOD && !hit);

  wire [15:0] bc_w = (in_bytes_q > CRC_BYTES) ? in_bytes_q - CRC_BYTES : 16'h0000;
  wire [DATA_W-1:0] sts_word = {bc_w, 10'h000, err_w};

  // ----------------------------------------------------------------
  // FIFO write mux
  // ----------------------------------------------------------------
  wire term_wr = in_st_q == RX_TERM && f_wr_ready;
  wire sts_wr  = in_st_q == RX_STS && f_wr_ready && !pend_q;
  wire pend_wr = in_idle && pend_q && !beat && f_wr_ready;
  wire f_wr    = data_wr || term_wr || sts_wr || pend_wr;

  wire [ENTRY_W-1:0] f_wdata =
    data_wr ? {1'b0, rx_in_eop, rx_in_data} :
    term_wr ? {1'b0, 1'b1, {DATA_W{1'b0}}} :
    sts_wr  ? {1'b1, 1'b0, sts_word} :
              {1'b1, 1'b0, pend_word_q};

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  wire head_eop  = f_rd_valid && f_rd_data[E_EOP];
  wire head_sts  = f_rd_valid && f_rd_data[E_STS];
  wire running   = out_st_q == OUT_RUN;
  wire load      = running && flush_q == 16'h0000 && (!out_valid_q || sys_out_ready);
  wire abort_ok  = running && (mid_q || (out_valid_q && !out_sts_q));
  wire auto_ab   = external && auto_rx_abort_en;
  wire abort_req = abort_ok && (rx_abort_in || auto_ab);
  wire drop_pop  = (out_st_q == OUT_DRAIN && f_rd_valid) ||
                   (out_st_q == OUT_DROPSTS && head_sts && !abort_keeps_status);
  wire f_rd      = (load && f_rd_valid && !abort_req) || drop_pop;
  wire out_take  = out_valid_q && sys_out_ready;
  wire rx_under  = running && mid_q && sys_out_ready && !out_valid_q &&
                   !f_rd_valid;
  wire [DATA_W-1:0] head_word = big_endian ? swap32(f_rd_data[DATA_W-1:0])
                                           : f_rd_data[DATA_W-1:0];

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  wire tx_disc  = tx_st_q == TX_RUN && (tx_fifo_underflow || tx_fifo_overflow);
  wire tx_set   = tx_disc && tx_sys_busy;
  wire rx_set   = external || rx_under;
  wire eop_evt  = (out_take && out_eop_q && !out_sts_q) || tx_pkt_end;
  wire auto_clr = clr_cnt_q == 2'h1;
  // An event in the same cycle as a clear wins
  wire rx_flag_d = rx_set || (rx_flag_q && !rx_discard_clear && !auto_clr);
  wire tx_flag_d = tx_set || (tx_flag_q && !tx_discard_clear && !auto_clr);

  // ----------------------------------------------------------------
  // Next states
  // ----------------------------------------------------------------
  always_comb begin
    in_st_d = in_st_q;
    case (in_st_q)
      RX_IDLE:   if (sop_beat && !rx_in_eop) in_st_d = RX_DATA;
                 else if (sop_beat) in_st_d = RX_DECIDE;
      RX_DATA:   if (in_eop) in_st_d = RX_DECIDE;
      RX_DECIDE: begin
        if (internal) begin
          in_st_d = sts_want ? RX_STS : RX_IDLE;
        end else if (eop_lost_q) begin
          in_st_d = RX_TERM;
        end else begin
          in_st_d = sts_want ? RX_STS : RX_IDLE;
        end
      end
      RX_TERM:   if (f_wr_ready) in_st_d = sts_want ? RX_STS : RX_IDLE;
      RX_STS:    in_st_d = RX_IDLE;
      default:   in_st_d = RX_IDLE;
    endcase
  end

  always_comb begin
    out_st_d = out_st_q;
    case (out_st_q)
      OUT_RUN: begin
        if (abort_req) begin
          out_st_d = mid_q ? OUT_DRAIN : OUT_DROPSTS;
        end
      end
      OUT_DRAIN: if (head_eop && !head_sts) out_st_d = OUT_DROPSTS;
      // Without abort_keeps_status, waits for the word after the packet; keeps it unless it is status
      OUT_DROPSTS: if (abort_keeps_status || f_rd_valid) out_st_d = OUT_RUN;
      default: out_st_d = OUT_RUN;
    endcase
  end

  always_comb begin
    tx_st_d = tx_st_q;
    case (tx_st_q)
      TX_IDLE: if (tx_pkt_active) tx_st_d = TX_RUN;
      TX_RUN: begin
        if (tx_disc) begin
          tx_st_d = TX_ERR;
        end else if (tx_pkt_end) begin
          tx_st_d = TX_IDLE;
        end
      end
      TX_ERR:  tx_st_d = TX_HOLD;
      TX_HOLD: if (!tx_sys_busy && !tx_pkt_active) tx_st_d = TX_IDLE;
      default: tx_st_d = TX_IDLE;
    endcase
  end

  wire [1:0] tx_code_d = tx_st_d == TX_RUN ? TXC_DATA :
                         tx_st_d == TX_ERR ? TXC_ERR : TXC_IDLE;
  wire tx_ready_d = tx_st_d != TX_ERR && tx_st_d != TX_HOLD;
  wire [15:0] flush_ld = (in_bytes_q >> FLUSH_SHIFT) + FLUSH_EXTRA;

  // ----------------------------------------------------------------
  // FIFO
  // ----------------------------------------------------------------
  rx_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .nrst     (nrst),
    .wr_valid (f_wr),
    .wr_ready (f_wr_ready),
    .wr_data  (f_wdata),
    .mark     (sop_beat),
    .rewind   (internal),
    .rd_valid (f_rd_valid),
    .rd_ready (f_rd),
    .rd_data  (f_rd_data),
    .level    (f_level)
  );

  // ----------------------------------------------------------------
  // Ingress registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      in_st_q     <= RX_IDLE;
      in_bytes_q  <= 16'h0000;
      pkt_words_q <= 16'h0000;
      rx_overflow_flag_q      <= 1'b0;
      code_q      <= 1'b0;
      crc_q       <= 1'b0;
      eop_lost_q  <= 1'b0;
      aborted_q   <= 1'b0;
    end else begin
      in_st_q <= in_st_d;
      if (sop_beat) begin
        in_bytes_q  <= data_wr ? 16'(rx_in_nbytes) : 16'h0000;
        pkt_words_q <= data_wr ? 16'h0001 : 16'h0000;
        rx_overflow_flag_q      <= rx_overflow_flag_evt;
        code_q      <= rx_in_code_err;
        aborted_q   <= 1'b0;
      end else if (beat) begin
        if (data_wr) begin
          in_bytes_q  <= in_bytes_q + 16'(rx_in_nbytes);
          pkt_words_q <= pkt_words_q + 16'h0001;
        end
        rx_overflow_flag_q <= rx_overflow_flag_q || rx_overflow_flag_evt;
        code_q <= code_q || rx_in_code_err;
      end
      if (in_eop) begin
        crc_q      <= rx_in_crc_bad;
        eop_lost_q <= !data_wr;
      end
      if (abort_req && in_st_q == RX_DATA) begin
        aborted_q <= 1'b1;
      end
    end
  end

  // Status kept back while the FIFO is full; later ones mark it as a run
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pend_q      <= 1'b0;
      pend_word_q <= '0;
    end else if (in_st_q == RX_STS && !sts_wr) begin
      pend_q <= 1'b1;
      if (pend_q) begin
        pend_word_q[ST_MULTI] <= 1'b1;
      end else begin
        pend_word_q <= sts_word;
      end
    end else if (pend_wr) begin
      pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_st_q    <= OUT_RUN;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
      out_eop_q   <= 1'b0;
      out_sts_q   <= 1'b0;
      mid_q       <= 1'b0;
      flush_q     <= 16'h0000;
    end else begin
      out_st_q <= out_st_d;
      if (abort_req) begin
        out_valid_q <= 1'b0;
        flush_q     <= flush_ld;
      end else if (flush_q != 16'h0000) begin
        flush_q <= flush_q - 16'h0001;
      end
      if (load && !abort_req) begin
        out_valid_q <= f_rd_valid;
        out_data_q  <= head_word;
        out_eop_q   <= f_rd_data[E_EOP];
        out_sts_q   <= f_rd_data[E_STS];
      end else if (out_take) begin
        out_valid_q <= 1'b0;
      end
      if (f_rd && !head_sts) begin
        mid_q <= !f_rd_data[E_EOP] && out_st_q == OUT_RUN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags, transmit path and registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clr_cnt_q <= 2'h0;
      rx_flag_q <= 1'b0;
      tx_flag_q <= 1'b0;
    end else begin
      rx_flag_q <= rx_flag_d;
      tx_flag_q <= tx_flag_d;
      if (auto_clear_en && eop_evt) begin
        clr_cnt_q <= AUTO_CLR_DELAY;
      end else if (clr_cnt_q != 2'h0) begin
        clr_cnt_q <= clr_cnt_q - 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_st_q    <= TX_IDLE;
      tx_code_q  <= TXC_IDLE;
      tx_ready_q <= 1'b1;
      rx_ready_q <= 1'b0;
    end else begin
      tx_st_q    <= tx_st_d;
      tx_code_q  <= tx_code_d;
      tx_ready_q <= tx_ready_d;
      rx_ready_q <= f_wr_ready;
    end
  end

  assign rx_in_ready     = rx_ready_q;
  assign sys_out_valid   = out_valid_q;
  assign sys_out_data    = out_data_q;
  assign sys_out_eop     = out_eop_q;
  assign sys_out_status  = out_sts_q;
  assign rx_discard_flag = rx_flag_q;
  assign tx_discard_flag = tx_flag_q;
  assign tx_sys_ready    = tx_ready_q;
  assign tx_code         = tx_code_q;
endmodule
